// ==== hdl/acs_pkg.sv ====
// package with constants and types for the adc calibration sequencer
// Behaviour
// RULE_01 - low-power mode keeps spare core powered down
// RULE_02 - enable bit one selects low-power background mode
// RULE_03 - sleep delay sets spare core sleep time
// RULE_04 - settle delay idles woken core before calibration
// RULE_05 - select bit picks timed or trigger switching
// RULE_06 - avoid low-power mode in single-channel operation; lp_mode does not check the single bit, so it is not blocked
// RULE_07 - separate input-buffer offset calibration is provided
// RULE_08 - foreground offset calibration runs once per run
// RULE_09 - background offset calibration updates every pass
// RULE_10 - set offset enable before calibration enable
// RULE_11 - offset trims written by calibration, not software
// RULE_12 - read offsets only after foreground done flag
// RULE_13 - user trimming only in foreground mode
// RULE_14 - dual mode uses zero-phase trims per input
// RULE_15 - single mode moves quadrature and zero trims
// RULE_16 - gain trim bank chosen by channel mode
// RULE_17 - restore full-scale defaults before gain trimming
// RULE_18 - core gain: both banks same direction
// RULE_19 - bank mismatch: banks opposite directions
// RULE_20 - foreground calibration forces mid-code output
// RULE_21 - trigger source is pin or software bit
// RULE_22 - automatic switching steps sleep, settle, calibrate, swap
// RULE_23 - delay counters load settings each phase
package acs_pkg;
   // register byte offsets
   localparam logic [7:0] ACS_CTRL_OFS = 8'h00;
   localparam logic [7:0] ACS_DLY_OFS = 8'h04;
   localparam logic [7:0] ACS_TRIG_OFS = 8'h08;
   localparam logic [7:0] ACS_STAT_OFS = 8'h0c;
   localparam logic [7:0] ACS_OFSA_OFS = 8'h10;
   localparam logic [7:0] ACS_OFSB_OFS = 8'h14;
   localparam logic [7:0] ACS_OFSQ_OFS = 8'h18;
   localparam logic [7:0] ACS_OFSZ_OFS = 8'h1c;
   localparam logic [7:0] ACS_GDUAL_OFS = 8'h20;
   localparam logic [7:0] ACS_GSING_OFS = 8'h24;
   // control field positions
   localparam int ACS_CTRL_CAL_EN = 0;
   localparam int ACS_CTRL_BG = 1;
   localparam int ACS_CTRL_OS = 2;
   localparam int ACS_CTRL_BGOS = 3;
   localparam int ACS_CTRL_LP = 4;
   localparam int ACS_CTRL_LPSEL = 5;
   localparam int ACS_CTRL_TSEL = 6;
   localparam int ACS_CTRL_SINGLE = 7;
   // reset values
   localparam logic [7:0] ACS_CTRL_RST = 8'h00;
   localparam logic [15:0] ACS_DLY_RST = 16'h1010;
   localparam logic [11:0] ACS_TRIM_RST = 12'h800;
   localparam logic [11:0] ACS_MID_CODE = 12'h000;
   // cycle counts of calibration steps
   localparam logic [7:0] ACS_CAL_CYC = 8'h40;
   localparam logic [7:0] ACS_OS_CYC = 8'h20;
   localparam int ACS_DLY_SHIFT = 4;
   // axi response codes
   localparam logic [1:0] ACS_RESP_OK = 2'h0;
   localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;
   // sequencer states
   typedef enum logic [6:0] {
      ACS_ST_IDLE = 7'h01,
      ACS_ST_FGCAL = 7'h02,
      ACS_ST_FGOS = 7'h04,
      ACS_ST_SLEEP = 7'h08,
      ACS_ST_SETTLE = 7'h10,
      ACS_ST_BGCAL = 7'h20,
      ACS_ST_SWAP = 7'h40
   } acs_state_type;
   // analog core control bundle
   typedef struct packed {
      logic spare_power;
      logic cal_active;
      logic os_active;
      logic swap_pulse;
      logic [1:0] spare_core;
   } acs_core_ctl_type;
endpackage : acs_pkg

// ==== hdl/acs_sequencer.sv ====
// adc calibration sequencer with axi4-lite registers
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
module acs_sequencer
   import acs_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // axi4-lite write
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // axi4-lite read
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // calibration trigger pin
   input wire logic i_calibration_trigger_pin,
   // analog core side
   input wire logic [11:0] i_sample,
   input wire logic [11:0] i_offset_estimate,
   output logic [11:0] o_sample,
   output acs_core_ctl_type o_core_ctl,
   output logic [11:0] o_offset_trim_in_a,
   output logic [11:0] o_offset_trim_in_b,
   output logic [11:0] o_gain_trim
);
   // software registers
   logic [7:0] ctrl_q;
   logic [15:0] dly_q;
   logic soft_trig_q;
   logic [11:0] ofs_a_q, ofs_b_q, ofs_q_q, ofs_z_q;
   logic [11:0] gdual_q, gsing_q;
   logic foreground_finished_flag_q;
   // sequencer state
   acs_state_type st_q;
   logic [11:0] cnt_q;
   logic [1:0] spare_q;
   logic pwr_q, swap_q;
   logic os_once_q;
   logic trig_prev_q;
   // axi holding registers
   logic aw_got_q, w_got_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   // decoded controls
   logic lp_mode, bg_mode, os_any, trig_lvl, trig_rise, do_write;
   logic wr_ofs_ok, wr_gain_ok;
   // background mode keeps the sequencer cycling
   assign bg_mode = ctrl_q[ACS_CTRL_BG];
   assign lp_mode = bg_mode & ctrl_q[ACS_CTRL_LP]; // RULE_02
   assign os_any = ctrl_q[ACS_CTRL_OS] | ctrl_q[ACS_CTRL_BGOS];
   // trigger from pin or software bit
   assign trig_lvl = ctrl_q[ACS_CTRL_TSEL] ? i_calibration_trigger_pin : soft_trig_q; // RULE_21
   assign trig_rise = trig_lvl & ~trig_prev_q;
   // commit once both halves are held and no response is pending
   assign do_write = aw_got_q & w_got_q & ~o_bvalid;
   // blocked trim writes are dropped silently, not errored
   assign wr_ofs_ok = ~os_any & ~bg_mode; // RULE_11 RULE_13
   assign wr_gain_ok = ~bg_mode; // RULE_13

   // axi write channel capture, either order
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= ACS_RESP_OK;
      end else begin
         // readies drop on the taking edge and stay low while a half is held
         o_awready <= ~aw_got_q & ~(i_awvalid & o_awready);
         o_wready <= ~w_got_q & ~(i_wvalid & o_wready);
         if (i_awvalid && o_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
         end
         // response after both halves
         if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= ACS_GSING_OFS) ?
                       ACS_RESP_OK : ACS_RESP_SLVERR;
         end else if (o_bvalid && i_bready) begin
            // response taken: free both halves and reopen the readies
            o_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   // register writes and calibration result updates
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         ctrl_q <= ACS_CTRL_RST;
         dly_q <= ACS_DLY_RST;
         soft_trig_q <= 1'b0;
         ofs_a_q <= ACS_TRIM_RST;
         ofs_b_q <= ACS_TRIM_RST;
         ofs_q_q <= ACS_TRIM_RST;
         ofs_z_q <= ACS_TRIM_RST;
         gdual_q <= ACS_TRIM_RST;
         gsing_q <= ACS_TRIM_RST;
      end else begin
         // the low byte lane strobe alone gates every field write
         if (do_write && wstrb_q[0]) begin
            case (awaddr_q)
               ACS_CTRL_OFS: ctrl_q <= wdata_q[7:0];
               ACS_DLY_OFS: dly_q <= wdata_q[15:0];
               ACS_TRIG_OFS: soft_trig_q <= wdata_q[0];
               ACS_OFSA_OFS: if (wr_ofs_ok) ofs_a_q <= wdata_q[11:0];
               ACS_OFSB_OFS: if (wr_ofs_ok) ofs_b_q <= wdata_q[11:0];
               ACS_OFSQ_OFS: if (wr_ofs_ok) ofs_q_q <= wdata_q[11:0];
               ACS_OFSZ_OFS: if (wr_ofs_ok) ofs_z_q <= wdata_q[11:0];
               ACS_GDUAL_OFS: if (wr_gain_ok) gdual_q <= wdata_q[11:0];
               ACS_GSING_OFS: if (wr_gain_ok) gsing_q <= wdata_q[11:0];
               default: ;
            endcase
         end
         // a calibration result wins over a same-cycle software write
         // offset results land in the trims, per channel mode
         if ((st_q == ACS_ST_FGOS || (st_q == ACS_ST_BGCAL && ctrl_q[ACS_CTRL_BGOS]))
             && cnt_q == 12'h001) begin // RULE_11
            if (ctrl_q[ACS_CTRL_SINGLE]) begin
               ofs_q_q <= i_offset_estimate;
               ofs_z_q <= i_offset_estimate;
            end else begin
               ofs_a_q <= i_offset_estimate; // RULE_14
               ofs_b_q <= i_offset_estimate; // RULE_14
            end
         end
      end
   end

   // axi read channel
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= ACS_RESP_OK;
      end else begin
         // one read at a time: arready stays low while data is offered
         o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
         if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp <= ACS_RESP_OK;
            case (i_araddr)
               ACS_CTRL_OFS: o_rdata <= {24'h000000, ctrl_q};
               ACS_DLY_OFS: o_rdata <= {16'h0000, dly_q};
               ACS_TRIG_OFS: o_rdata <= {31'h0, soft_trig_q};
               // status: spare core index, one-hot state, finished flag
               ACS_STAT_OFS: o_rdata <= {22'h0, spare_q, st_q, foreground_finished_flag_q};
               ACS_OFSA_OFS: o_rdata <= {20'h00000, ofs_a_q};
               ACS_OFSB_OFS: o_rdata <= {20'h00000, ofs_b_q};
               ACS_OFSQ_OFS: o_rdata <= {20'h00000, ofs_q_q};
               ACS_OFSZ_OFS: o_rdata <= {20'h00000, ofs_z_q};
               ACS_GDUAL_OFS: o_rdata <= {20'h00000, gdual_q};
               ACS_GSING_OFS: o_rdata <= {20'h00000, gsing_q};
               default: begin
                  o_rdata <= 32'h0000_0000;
                  o_rresp <= ACS_RESP_SLVERR;
               end
            endcase
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end

   // calibration sequencer
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st_q <= ACS_ST_FGCAL; // power-up runs foreground calibration
         cnt_q <= {4'h0, ACS_CAL_CYC};
         // third core starts as the spare
         spare_q <= 2'h2;
         pwr_q <= 1'b1;
         swap_q <= 1'b0;
         foreground_finished_flag_q <= 1'b0;
         os_once_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         // edge history starts low, like an idle trigger
         trig_prev_q <= trig_lvl;
         swap_q <= 1'b0;
         // shared down-counter, reloaded at each phase start
         if (cnt_q != 12'h000) cnt_q <= cnt_q - 12'h001;
         case (st_q)
            ACS_ST_IDLE: begin
               pwr_q <= ~lp_mode; // RULE_01
               // background mode wins over a foreground trigger
               if (bg_mode) begin
                  st_q <= lp_mode ? ACS_ST_SLEEP : ACS_ST_BGCAL;
                  cnt_q <= lp_mode ? {dly_q[7:0], 4'h0} : {4'h0, ACS_CAL_CYC}; // RULE_23
               end else if (trig_rise && ctrl_q[ACS_CTRL_CAL_EN]) begin
                  st_q <= ACS_ST_FGCAL;
                  cnt_q <= {4'h0, ACS_CAL_CYC};
                  foreground_finished_flag_q <= 1'b0;
                  os_once_q <= ctrl_q[ACS_CTRL_OS]; // RULE_10
               end
            end
            ACS_ST_FGCAL: begin
               // cores offline until the count runs out
               if (cnt_q == 12'h000) begin
                  if (os_once_q) begin
                     st_q <= ACS_ST_FGOS; // RULE_08
                     cnt_q <= {4'h0, ACS_OS_CYC};
                  end else begin
                     st_q <= ACS_ST_IDLE;
                     foreground_finished_flag_q <= 1'b1;
                  end
               end
            end
            ACS_ST_FGOS: begin
               // single offset step, then done
               if (cnt_q == 12'h000) begin
                  st_q <= ACS_ST_IDLE;
                  os_once_q <= 1'b0; // RULE_08
                  foreground_finished_flag_q <= 1'b1;
               end
            end
            ACS_ST_SLEEP: begin
               // spare core powered down while it waits
               pwr_q <= 1'b0; // RULE_01
               // timed wake, or trigger-only wake when the select bit is set
               if (!bg_mode) st_q <= ACS_ST_IDLE;
               else if (ctrl_q[ACS_CTRL_LPSEL] ? trig_rise : cnt_q == 12'h000) begin // RULE_03 RULE_05
                  st_q <= ACS_ST_SETTLE; // RULE_22
                  cnt_q <= {dly_q[15:8], 4'h0}; // RULE_23
               end
            end
            ACS_ST_SETTLE: begin
               // core powered and left idle to stabilise
               pwr_q <= 1'b1;
               if (cnt_q == 12'h000) begin
                  st_q <= ACS_ST_BGCAL; // RULE_04
                  cnt_q <= 12'({4'h0, ACS_CAL_CYC} +
                           (ctrl_q[ACS_CTRL_BGOS] ? {4'h0, ACS_OS_CYC} : 12'h000)); // RULE_09
               end
            end
            ACS_ST_BGCAL: begin
               // spare core calibrating, offset step folded into the count only when entered from settle
               pwr_q <= 1'b1;
               if (cnt_q == 12'h000) st_q <= ACS_ST_SWAP;
            end
            ACS_ST_SWAP: begin
               // spare core swaps in; released core becomes spare
               swap_q <= 1'b1; // RULE_22
               spare_q <= (spare_q == 2'h2) ? 2'h0 : spare_q + 2'h1;
               // low-power mode sends the released core to sleep
               st_q <= lp_mode ? ACS_ST_SLEEP : ACS_ST_IDLE;
               cnt_q <= {dly_q[7:0], 4'h0}; // RULE_23
            end
            default: st_q <= ACS_ST_IDLE;
         endcase
      end
   end

   // analog side outputs
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_sample <= ACS_MID_CODE;
         o_core_ctl <= '0;
         o_offset_trim_in_a <= ACS_TRIM_RST;
         o_offset_trim_in_b <= ACS_TRIM_RST;
         o_gain_trim <= ACS_TRIM_RST;
      end else begin
         // mid-code while foreground calibration runs
         o_sample <= (st_q == ACS_ST_FGCAL || st_q == ACS_ST_FGOS) ? ACS_MID_CODE : i_sample; // RULE_20
         // core control bundle, swap pulse lasts one cycle
         o_core_ctl <= '{spare_power: pwr_q, cal_active: st_q != ACS_ST_IDLE,
                         os_active: st_q == ACS_ST_FGOS, swap_pulse: swap_q,
                         spare_core: spare_q}; // RULE_07
         // applied trims follow the channel mode
         o_offset_trim_in_a <= ctrl_q[ACS_CTRL_SINGLE] ? ofs_q_q : ofs_a_q; // RULE_14
         o_offset_trim_in_b <= ctrl_q[ACS_CTRL_SINGLE] ? ofs_z_q : ofs_b_q;
         o_gain_trim <= ctrl_q[ACS_CTRL_SINGLE] ? gsing_q : gdual_q; // RULE_16
      end
   end
endmodule : acs_sequencer

// ==== tb/acs_sequencer_chk.sv ====
// checker for the sequencer bus handshakes and core outputs
`timescale 1ns/100ps
module acs_sequencer_chk
   import acs_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // bus handshakes
   input wire logic o_awready,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic [31:0] o_rdata,
   input wire logic i_rready,
   // core side
   input wire logic [11:0] o_sample,
   input wire acs_core_ctl_type o_core_ctl,
   input wire logic [11:0] o_offset_trim_in_a,
   input wire logic [11:0] o_gain_trim
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // power-up calibration shows mid-code
   mid_code_a: assert property ($rose(i_rst_n) |-> (o_sample == ACS_MID_CODE) [*8])
      else $error("sample not mid-code after reset");
   trim_reset_a: assert property ($rose(i_rst_n) |-> o_offset_trim_in_a == ACS_TRIM_RST
      && o_gain_trim == ACS_TRIM_RST) else $error("trim not at reset value");
   // response handshakes
   bvalid_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped early");
   bvalid_drop_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
      else $error("write response repeated");
   ready_low_a: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("ready high with response pending");
   read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data not held");
   rvalid_drop_a: assert property (o_rvalid && i_rready |=> !o_rvalid)
      else $error("read response repeated");
   // swap is a single pulse
   swap_pulse_a: assert property ($rose(o_core_ctl.swap_pulse) |=> !o_core_ctl.swap_pulse)
      else $error("swap pulse too long");
   // offset step runs with the cores offline
   os_midcode_a: assert property (o_core_ctl.os_active |-> o_sample == ACS_MID_CODE)
      else $error("offset step without mid-code");
   // each swap hands the spare role to another core
   spare_rotate_a: assert property (o_core_ctl.swap_pulse |->
      o_core_ctl.spare_core != $past(o_core_ctl.spare_core))
      else $error("spare core unchanged at swap");
   // main scenarios
   swap_c: cover property (o_core_ctl.swap_pulse);
   wresp_c: cover property (o_bvalid && i_bready);
   rresp_c: cover property (o_rvalid && i_rready);
endmodule : acs_sequencer_chk
bind acs_sequencer acs_sequencer_chk i_chk (.i_mclk, .i_rst_n, .o_awready, .o_wready,
   .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid, .o_rdata, .i_rready,
   .o_sample, .o_core_ctl, .o_offset_trim_in_a, .o_gain_trim);

// ==== tb/testbench.sv ====
// self-checking bench for the calibration sequencer
`timescale 1ns/100ps
module testbench;
   import acs_pkg::*;
   // stimulus and observed signals
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic i_arvalid = 1'b0, i_rready = 1'b0, i_calibration_trigger_pin = 1'b0;
   logic [31:0] i_wdata = 32'h0, o_rdata, rd_v;
   logic [3:0] i_wstrb = 4'h0;
   logic [11:0] i_sample = 12'h001, i_offset_estimate = 12'h000, e, o_sample;
   logic [11:0] o_offset_trim_in_a, o_offset_trim_in_b, o_gain_trim;
   logic [11:0] t[6];
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp;
   acs_core_ctl_type o_core_ctl;
   logic [34:0] rq[$];
   logic [1:0] bq[$];
   int failures = 0, checked = 0, cyc = 0, n, m, k;
   acs_sequencer i_dut (.i_mclk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_calibration_trigger_pin,
      .i_sample, .i_offset_estimate, .o_sample, .o_core_ctl, .o_offset_trim_in_a,
      .o_offset_trim_in_b, .o_gain_trim);
   // clock, live samples never zero, hang limit
   always #2 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      i_sample <= 12'($urandom) | 12'h001;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         wrap_up();
      end
   end
   // compare and count
   task chk(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // watcher takes the oldest note at each response
   always @(posedge i_mclk) begin
      if (o_rvalid && i_rready && rq.size() > 0) begin
         if (rq[0][34])
            chk({o_rresp, o_rdata}, rq[0][33:0]);
         void'(rq.pop_front());
      end
      if (o_bvalid && i_bready && bq.size() > 0)
         chk(34'(o_bresp), 34'(bq.pop_front()));
   end
   // bus write, both channels offered together
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge i_mclk);
      bq.push_back(r);
      i_awaddr <= a;
      i_wdata <= d;
      i_wstrb <= 4'hf;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      // bready raised once the response shows, so the response stands a cycle
      do begin
         @(posedge i_mclk);
         if (o_awready)
            i_awvalid <= 1'b0;
         if (o_wready)
            i_wvalid <= 1'b0;
         if (o_bvalid === 1'b1 && i_bready !== 1'b1)
            i_bready <= 1'b1;
      end while (!(o_bvalid === 1'b1 && i_bready === 1'b1));
      i_bready <= 1'b0;
   endtask : wr
   // bus read, data kept in rd_v
   task rd(input logic [7:0] a, input logic c, input logic [33:0] x);
      @(posedge i_mclk);
      rq.push_back({c, x});
      i_araddr <= a;
      i_arvalid <= 1'b1;
      // rready raised once data shows, so the data must stand a cycle
      do begin
         @(posedge i_mclk);
         if (o_arready)
            i_arvalid <= 1'b0;
         if (o_rvalid === 1'b1 && i_rready !== 1'b1)
            i_rready <= 1'b1;
      end while (!(o_rvalid === 1'b1 && i_rready === 1'b1));
      rd_v = o_rdata;
      i_rready <= 1'b0;
   endtask : rd
   task rx(input logic [7:0] a, input logic [31:0] v);
      rd(a, 1'b1, {ACS_RESP_OK, v});
   endtask : rx
   // wait on the finished flag
   task poll_done();
      for (k = 0; k < 100; k++) begin
         rd(ACS_STAT_OFS, 1'b0, 34'h0);
         if (rd_v[0] === 1'b1)
            break;
      end
      chk(34'(rd_v[0]), 34'h1);
   endtask : poll_done
   task ns(input int c);
      repeat (c) @(negedge i_mclk);
   endtask : ns
   // count swaps and powered-down spare cycles
   task count(input int c);
      n = 0;
      m = 0;
      repeat (c) begin
         @(negedge i_mclk);
         n += int'(o_core_ctl.swap_pulse === 1'b1);
         m += int'(o_core_ctl.spare_power === 1'b0);
      end
   endtask : count
   task wrap_up();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   // main sequence
   initial begin
      void'($urandom(32'haa43));
      repeat (16) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      poll_done();
      chk(34'(o_offset_trim_in_b), 34'(ACS_TRIM_RST));
      rx(ACS_CTRL_OFS, 32'(ACS_CTRL_RST));
      rx(ACS_DLY_OFS, 32'(ACS_DLY_RST));
      rd(8'h28, 1'b1, {ACS_RESP_SLVERR, 32'h0});
      wr(8'h28, 32'h1, ACS_RESP_SLVERR);
      $display("test reset done");
      // trims land in the bank of the channel mode
      foreach (t[i]) begin
         t[i] = 12'($urandom);
         wr(ACS_OFSA_OFS + 8'(4 * i), 32'(t[i]), ACS_RESP_OK);
      end
      ns(1);
      chk(34'(o_offset_trim_in_a), 34'(t[0]));
      chk(34'(o_offset_trim_in_b), 34'(t[1]));
      chk(34'(o_gain_trim), 34'(t[4]));
      wr(ACS_CTRL_OFS, 32'h80, ACS_RESP_OK);
      ns(1);
      chk(34'(o_gain_trim), 34'(t[5]));
      chk(34'(o_offset_trim_in_a), 34'(t[2]));
      chk(34'(o_offset_trim_in_b), 34'(t[3]));
      $display("test trims done");
      // offset enable first, software write then dropped
      wr(ACS_CTRL_OFS, 32'h04, ACS_RESP_OK);
      wr(ACS_OFSA_OFS, 32'(~t[0]), ACS_RESP_OK);
      rx(ACS_OFSA_OFS, 32'(t[0]));
      e = 12'($urandom);
      i_offset_estimate <= e;
      wr(ACS_CTRL_OFS, 32'h05, ACS_RESP_OK);
      wr(ACS_TRIG_OFS, 32'h1, ACS_RESP_OK);
      ns(4);
      chk(34'(o_sample), 34'(ACS_MID_CODE));
      poll_done();
      i_offset_estimate <= ~e;
      ns(1);
      chk(34'(o_offset_trim_in_a), 34'(e));
      chk(34'(o_offset_trim_in_b), 34'(e));
      rx(ACS_OFSA_OFS, 32'(e));
      ns(200);
      chk(34'(o_offset_trim_in_a), 34'(e));
      $display("test offset done");
      // pin selected, software edge ignored
      wr(ACS_TRIG_OFS, 32'h0, ACS_RESP_OK);
      wr(ACS_CTRL_OFS, 32'h41, ACS_RESP_OK);
      wr(ACS_TRIG_OFS, 32'h1, ACS_RESP_OK);
      rd(ACS_STAT_OFS, 1'b0, 34'h0);
      chk(34'(rd_v[7:0]), 34'h03);
      i_calibration_trigger_pin <= 1'b1;
      ns(4);
      chk(34'(o_sample), 34'(ACS_MID_CODE));
      poll_done();
      i_calibration_trigger_pin <= 1'b0;
      $display("test pin done");
      // standard then low-power background cycling
      wr(ACS_DLY_OFS, 32'h0101, ACS_RESP_OK);
      wr(ACS_CTRL_OFS, 32'h02, ACS_RESP_OK);
      count(400);
      chk(34'(n > 0), 34'h1);
      chk(34'(m), 34'h0);
      e = 12'($urandom);
      i_offset_estimate <= e;
      wr(ACS_CTRL_OFS, 32'h1a, ACS_RESP_OK);
      count(800);
      chk(34'(n > 0), 34'h1);
      chk(34'(m >= 16), 34'h1);
      chk(34'(o_offset_trim_in_a), 34'(e));
      wr(ACS_GDUAL_OFS, 32'(~t[4]), ACS_RESP_OK);
      rx(ACS_GDUAL_OFS, 32'(t[4]));
      wr(ACS_TRIG_OFS, 32'h0, ACS_RESP_OK);
      wr(ACS_CTRL_OFS, 32'h3a, ACS_RESP_OK);
      count(300);
      count(400);
      chk(34'(n), 34'h0);
      wr(ACS_TRIG_OFS, 32'h1, ACS_RESP_OK);
      count(400);
      chk(34'(n > 0), 34'h1);
      $display("test background done");
      wrap_up();
   end
endmodule : testbench
